// >>> lsq_pkg.sv
// Package for the list sequencer: register map, field layout, timing.
// Assumes a 32-bit classic Wishbone slave bus and a 10 MHz system clock.
`default_nettype none
package lsq_pkg;
    // ==================================================================
    // Table sizes
    localparam int DATA_DEPTH = 1002;
    localparam int SEQ_DEPTH  = 512;
    localparam int WIN_LEN    = 16;
    // ==================================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_REPEAT  = 8'h04;
    localparam logic [7:0] OFS_SKIP    = 8'h08;
    localparam logic [7:0] OFS_QPTR    = 8'h0c;
    localparam logic [7:0] OFS_LEVEL   = 8'h10;
    localparam logic [7:0] OFS_DWELL   = 8'h14;
    localparam logic [7:0] OFS_ORDER   = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1c;
    localparam logic [7:0] OFS_MODE    = 8'h20;
    localparam logic [7:0] OFS_TRANS   = 8'h24;
    localparam logic [7:0] OFS_ERROR   = 8'h28;
    localparam logic [7:0] OFS_FILL    = 8'h2c;
    localparam logic [7:0] OFS_WINSEL  = 8'h30;
    localparam logic [7:0] OFS_WIN0    = 8'h40;
    localparam logic [7:0] OFS_WIN_END = 8'h7c;
    // ==================================================================
    // Control register fields
    localparam int CTRL_ORDER = 0;
    localparam int CTRL_DIR   = 1;
    localparam int CTRL_CLEAR = 2;
    // Output mode codes
    localparam logic [1:0] MODE_FIXED = 2'h0;
    localparam logic [1:0] MODE_LIST  = 2'h1;
    localparam logic [1:0] MODE_TRANS = 2'h2;
    // Window table select codes
    localparam logic [1:0] WIN_SEQ   = 2'h0;
    localparam logic [1:0] WIN_LEVEL = 2'h1;
    localparam logic [1:0] WIN_DWELL = 2'h2;
    // Settings conflict error code, two's complement of -221
    localparam logic [15:0] ERR_CONFLICT = 16'hff23;
    // ==================================================================
    // Timing: dwell values count in 1 ms units
    localparam int CLK_HZ        = 10_000_000;
    localparam int TICK_US       = 1000;
    localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
    // Reset values
    localparam logic [31:0] RST_REPEAT = 32'h0000_0001;
endpackage
`default_nettype wire

// >>> lsq_list_sequencer.sv
// List sequencer: level, dwell and order tables stepped out to a level.
// Assumes a classic Wishbone master on clk_sys, synchronous inputs.
`default_nettype none
module lsq_list_sequencer
    import lsq_pkg::*;
#(
    parameter int LEVEL_W = 16,
    parameter int DWELL_W = 16
)(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic [LEVEL_W-1:0] level_out,
    output logic             list_running
);
    // ==================================================================
    // State
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_TRANS = 3'b100
    } lsq_state_type;

    typedef struct packed {
        lsq_state_type       st;
        logic                order_user;
        logic                dir_rev;
        logic [31:0]         repeat_cnt;
        logic [9:0]          skip_n;
        logic [9:0]          qptr;
        logic [9:0]          level_fill;
        logic [9:0]          dwell_fill;
        logic [9:0]          order_fill;
        logic [1:0]          win_sel;
        logic [15:0]         err;
        logic [9:0]          step;
        logic [9:0]          step_cnt;
        logic [31:0]         pass;
        logic [13:0]         tick;
        logic [DWELL_W-1:0]  dwell_ms;
        logic [LEVEL_W-1:0]  level;
        logic [LEVEL_W-1:0]  saved;
        logic [DWELL_W-1:0]  trans_ms;
        logic                trans_armed;
        logic [31:0]         rdata;
        logic                ack;
    } lsq_regs_type;

    lsq_regs_type r;
    lsq_regs_type next_r;

    // Table storage, written only from the clocked process
    logic [LEVEL_W-1:0] level_tab [DATA_DEPTH];
    logic [DWELL_W-1:0] dwell_tab [DATA_DEPTH];
    logic [9:0]         order_tab [SEQ_DEPTH];

    localparam logic [13:0] TICK_MAX = 14'(TICK_CYCLES - 1);

    logic        req;
    logic        wr;
    logic [9:0]  steps;
    logic [9:0]  first_step;
    logic [9:0]  loc;
    logic [9:0]  win_idx;
    logic [3:0]  win_off;
    logic        lvl_we;
    logic        dwl_we;
    logic        ord_we;

    assign req = wb_cyc_i & wb_stb_i & ~r.ack;
    assign wr  = req & wb_we_i;
    assign win_off = wb_adr_i[5:2];
    assign win_idx = r.qptr + 10'(win_off);

    // Steps per pass, and the location each step stands for
    assign steps = r.order_user ? r.order_fill : r.level_fill;
    assign loc   = r.order_user ? order_tab[r.step[8:0]]
                                : r.step;

    // ==================================================================
    // Next-state logic
    always_comb
    begin
        logic [9:0] nxt;
        logic       last;
        logic       list_cmd;
        nxt      = 10'h000;
        last     = 1'b0;
        list_cmd = 1'b0;
        next_r = r;
        next_r.ack = req;
        lvl_we = 1'b0;
        dwl_we = 1'b0;
        ord_we = 1'b0;
        first_step = 10'h000;
        // List commands are the table/setting registers and the window
        list_cmd = (wb_adr_i < OFS_STATUS) || (wb_adr_i == OFS_WINSEL)
                   || (wb_adr_i >= OFS_WIN0 && wb_adr_i <= OFS_WIN_END);

        // Bus reads
        next_r.rdata = 32'h0000_0000;
        if (req && !wb_we_i)
        begin
            if (r.st == ST_RUN && list_cmd)
                next_r.err = ERR_CONFLICT;
            else if (wb_adr_i == OFS_CTRL)
                next_r.rdata = {30'h0, r.dir_rev, r.order_user};
            else if (wb_adr_i == OFS_REPEAT)
                next_r.rdata = r.repeat_cnt;
            else if (wb_adr_i == OFS_SKIP)
                next_r.rdata = {22'h0, r.skip_n};
            else if (wb_adr_i == OFS_QPTR)
                next_r.rdata = {22'h0, r.qptr};
            else if (wb_adr_i == OFS_STATUS)
                next_r.rdata = {29'h0, r.st};
            else if (wb_adr_i == OFS_MODE)
                next_r.rdata = {30'h0, r.st == ST_RUN ? MODE_LIST :
                                r.trans_armed ? MODE_TRANS : MODE_FIXED};
            else if (wb_adr_i == OFS_ERROR)
                next_r.rdata = {16'h0, r.err};
            else if (wb_adr_i == OFS_FILL)
                next_r.rdata = {2'h0, r.order_fill, r.dwell_fill,
                                r.level_fill};
            else if (wb_adr_i == OFS_WINSEL)
                next_r.rdata = {30'h0, r.win_sel};
            else if (wb_adr_i >= OFS_WIN0 && wb_adr_i <= OFS_WIN_END)
            begin
                // Entries past the fill pointer read as zero
                if (r.win_sel == WIN_SEQ && win_idx < r.order_fill)
                    next_r.rdata = {22'h0, order_tab[win_idx[8:0]]};
                else if (r.win_sel == WIN_LEVEL && win_idx < r.level_fill)
                    next_r.rdata = 32'(level_tab[win_idx]);
                else if (r.win_sel == WIN_DWELL && win_idx < r.dwell_fill)
                    next_r.rdata = 32'(dwell_tab[win_idx]);
            end
        end

        // Bus writes
        if (wr && r.st == ST_RUN && list_cmd)
            next_r.err = ERR_CONFLICT;
        else if (wr && wb_sel_i[0])
        begin
            if (wb_adr_i == OFS_CTRL)
            begin
                next_r.order_user = wb_dat_i[CTRL_ORDER];
                next_r.dir_rev    = wb_dat_i[CTRL_DIR];
                if (wb_dat_i[CTRL_CLEAR])
                begin
                    next_r.level_fill = 10'h000;
                    next_r.dwell_fill = 10'h000;
                    next_r.order_fill = 10'h000;
                    next_r.qptr       = 10'h000;
                end
            end
            else if (wb_adr_i == OFS_REPEAT)
                next_r.repeat_cnt = wb_dat_i;
            else if (wb_adr_i == OFS_SKIP)
                next_r.skip_n = wb_dat_i[9:0];
            else if (wb_adr_i == OFS_QPTR && wb_dat_i < DATA_DEPTH)
                next_r.qptr = wb_dat_i[9:0];
            else if (wb_adr_i == OFS_LEVEL
                     && r.level_fill < 10'(DATA_DEPTH))
            begin
                lvl_we = 1'b1;
                next_r.level_fill = r.level_fill + 10'h001;
            end
            else if (wb_adr_i == OFS_DWELL
                     && r.dwell_fill < 10'(DATA_DEPTH))
            begin
                dwl_we = 1'b1;
                next_r.dwell_fill = r.dwell_fill + 10'h001;
            end
            else if (wb_adr_i == OFS_ORDER
                     && r.order_fill < 10'(SEQ_DEPTH))
            begin
                ord_we = 1'b1;
                next_r.order_fill = r.order_fill + 10'h001;
            end
            else if (wb_adr_i == OFS_WINSEL)
                next_r.win_sel = wb_dat_i[1:0];
            else if (wb_adr_i == OFS_ERROR)
                next_r.err = 16'h0000;
            else if (wb_adr_i == OFS_TRANS)
            begin
                next_r.trans_ms    = wb_dat_i[DWELL_W-1:0];
                next_r.trans_armed = 1'b1;
            end
            else if (wb_adr_i == OFS_MODE)
            begin
                if (wb_dat_i[1:0] == MODE_FIXED)
                begin
                    if (r.st == ST_RUN)
                    begin
                        next_r.st    = ST_IDLE;
                        next_r.level = r.saved;
                    end
                end
                else if (wb_dat_i[1:0] == MODE_LIST && r.st == ST_IDLE)
                begin
                    // Unbalanced tables refuse to start
                    if (steps == 10'h000 || (r.dwell_fill != 10'h001
                        && r.dwell_fill != r.level_fill))
                        next_r.err = ERR_CONFLICT;
                    else
                    begin
                        first_step = r.dir_rev ? steps - 10'h001
                                               : 10'h000;
                        next_r.st       = ST_RUN;
                        next_r.saved    = r.level;
                        next_r.step     = first_step;
                        next_r.step_cnt = 10'h000;
                        next_r.pass     = 32'h0000_0001;
                        next_r.tick     = 14'h0000;
                        next_r.dwell_ms = '0;
                    end
                end
            end
            else if (wb_adr_i == OFS_LEVEL + 8'h80)
            begin
                // Direct level command, possibly a transient
                next_r.level = wb_dat_i[LEVEL_W-1:0];
                if (r.trans_armed && r.st == ST_IDLE)
                begin
                    next_r.saved       = r.level;
                    next_r.st          = ST_TRANS;
                    next_r.trans_armed = 1'b0;
                    next_r.tick        = 14'h0000;
                    next_r.dwell_ms    = '0;
                end
            end
        end

        // Millisecond time base and step sequencing
        if (r.st != ST_IDLE && next_r.st == r.st)
        begin
            next_r.tick = (r.tick == TICK_MAX) ? 14'h0000
                                               : r.tick + 14'h0001;
            if (r.tick == TICK_MAX)
                next_r.dwell_ms = r.dwell_ms + 1'b1;
        end
        if (r.st == ST_RUN && next_r.st == ST_RUN)
        begin
            next_r.level = level_tab[loc];
            if (r.tick == TICK_MAX && (r.dwell_ms + 1'b1) >=
                dwell_tab[r.dwell_fill == 10'h001 ? 10'h000 : loc])
            begin
                next_r.dwell_ms = '0;
                last = r.step_cnt == steps - 10'h001;
                nxt  = r.dir_rev ? r.step - 10'h001 : r.step + 10'h001;
                if (last)
                begin
                    if (r.repeat_cnt != 0 && r.pass >= r.repeat_cnt)
                        next_r.st = ST_IDLE;
                    else
                    begin
                        next_r.pass = r.pass + 32'h0000_0001;
                        // Later passes skip the leading steps
                        next_r.step_cnt = (r.skip_n < steps) ? r.skip_n
                                                             : 10'h000;
                        next_r.step = r.dir_rev
                            ? steps - 10'h001 - next_r.step_cnt
                            : next_r.step_cnt;
                    end
                end
                else
                begin
                    next_r.step     = nxt;
                    next_r.step_cnt = r.step_cnt + 10'h001;
                end
            end
        end
        if (r.st == ST_TRANS && r.tick == TICK_MAX
            && (r.dwell_ms + 1'b1) >= r.trans_ms)
        begin
            next_r.st    = ST_IDLE;
            next_r.level = r.saved;
        end
    end

    // ==================================================================
    // State and table registers
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.repeat_cnt <= RST_REPEAT;
        end
        else
            r <= next_r;
    end

    // Tables have no reset; only fill pointers qualify their contents
    always_ff @(posedge clk_sys)
    begin
        if (lvl_we)
            level_tab[r.level_fill] <= wb_dat_i[LEVEL_W-1:0];
        if (dwl_we)
            dwell_tab[r.dwell_fill] <= wb_dat_i[DWELL_W-1:0];
        if (ord_we)
            order_tab[r.order_fill[8:0]] <= wb_dat_i[9:0];
    end

    assign wb_ack_o     = r.ack;
    assign wb_dat_o     = r.rdata;
    assign level_out    = r.level;
    assign list_running = r.st[1];          // One-hot run bit of the state
endmodule
`default_nettype wire

// >>> lsq_list_sequencer_assertions.sv
// Checker for the list sequencer, watching only the top ports.
// Assumes one clock domain and bind from the bench top file.
`default_nettype none
module lsq_list_sequencer_assertions
    import lsq_pkg::*;
#(
    parameter int LEVEL_W = 16
)(
    input wire logic               clk_sys,
    input wire logic               nrst,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic [LEVEL_W-1:0] level_out,
    input wire logic               list_running
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Decode of the request taken at this edge
    logic       take;
    logic       wr_ok;
    logic       rd_ok;
    logic       busy_area;
    logic       unmapped;
    logic [9:0] qptr_exp;
    logic [1:0] ctrl_exp;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ok = take & wb_we_i & wb_sel_i[0] & ~list_running;
    assign rd_ok = take & ~wb_we_i & ~list_running;
    assign busy_area = (wb_adr_i <= OFS_ORDER) | (wb_adr_i == OFS_WINSEL)
        | (wb_adr_i >= OFS_WIN0 && wb_adr_i <= OFS_WIN_END);
    assign unmapped = (wb_adr_i >= 8'h34 && wb_adr_i <= 8'h3c)
        | (wb_adr_i >= 8'h80 && wb_adr_i != 8'h90);
    // Shadow of pointer and control bits; writes while running are void
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            qptr_exp <= 10'h0;
            ctrl_exp <= 2'h0;
        end
        else if (wr_ok && wb_adr_i == OFS_CTRL)
        begin
            ctrl_exp <= wb_dat_i[1:0];
            if (wb_dat_i[CTRL_CLEAR])
                qptr_exp <= 10'h0;
        end
        else if (wr_ok && wb_adr_i == OFS_QPTR && wb_dat_i <= 32'd1001)
            qptr_exp <= wb_dat_i[9:0];
    end
    // ==========================================================
    // Bus answer: one pulse, one cycle after the take
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_answer: assert property (take |=> s_answer)
        else $error("ack not a single pulse after request");
    a_ack_cause: assert property (wb_ack_o |-> $past(take))
        else $error("ack without a request");
    a_busy_read: assert property (take && !wb_we_i && list_running
        && busy_area |=> wb_dat_o == 32'h0)
        else $error("list read answered while running");
    a_fixed_stops: assert property (take && wb_we_i && wb_sel_i[0]
        && list_running && wb_adr_i == OFS_MODE
        && wb_dat_i[1:0] == MODE_FIXED |-> ##[1:2] !list_running)
        else $error("fixed mode did not stop the list");
    a_unmapped_zero: assert property (take && !wb_we_i && unmapped
        |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_mode_running: assert property (take && !wb_we_i && list_running
        && wb_adr_i == OFS_MODE |=> wb_dat_o[1:0] == MODE_LIST)
        else $error("mode not list while running");
    a_qptr_value: assert property (rd_ok
        && wb_adr_i == OFS_QPTR |=> wb_dat_o == {22'h0, qptr_exp})
        else $error("query pointer read wrong");
    a_ctrl_value: assert property (rd_ok
        && wb_adr_i == OFS_CTRL |=> wb_dat_o[1:0] == ctrl_exp)
        else $error("order or direction read wrong");
endmodule
`default_nettype wire

// >>> lsq_host_model.sv
// Host model: classic Wishbone master issuing the register traffic.
// Assumes one clock; the bench calls xfer through the hierarchy.
`default_nettype none
module lsq_host_model (
    input  wire logic        clk_sys,
    input  wire logic        wb_ack_o,
    input  wire logic [31:0] wb_dat_o,
    output var  logic        wb_cyc,
    output var  logic        wb_stb,
    output var  logic        wb_we,
    output var  logic [7:0]  wb_adr,
    output var  logic [3:0]  wb_sel,
    output var  logic [31:0] wb_dat
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Idle bus from time zero
    initial
    begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we  = 1'b0;
        wb_adr = 8'h0;
        wb_sel = 4'h0;
        wb_dat = 32'h0;
    end
    // One cycle, held until ack is seen
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat <= d;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_sys);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb_list_sequencer.sv
// Bench for the list sequencer: register calls with expected values.
// Assumes the host model and checker files compile before this one.
`default_nettype none
module tb_list_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    import lsq_pkg::*;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        cyc, stb, we, ack, list_running;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r, rd_data;
    logic [15:0] level_out;
    int          err_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    lsq_list_sequencer #(.LEVEL_W(16), .DWELL_W(16)) lsq_list_sequencer_i (
        .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .level_out(level_out),
        .list_running(list_running));
    lsq_host_model lsq_host_model_i (
        .clk_sys(clk_sys), .wb_ack_o(ack), .wb_dat_o(dat_r), .wb_cyc(cyc),
        .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel),
        .wb_dat(dat_w));
    // ==========================================================
    // Clock and hang guard; runs and transient need about 91k cycles
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles >= 95000)
        begin
            err_count++;
            wrap_up();
        end
    end
    // ==========================================================
    // Access and compare tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        lsq_host_model_i.xfer(1'b1, a, d, rd_data);
    endtask
    task automatic check_word(input logic [7:0] a, input logic [31:0] e);
        lsq_host_model_i.xfer(1'b0, a, 32'h0, rd_data);
        n_tests++;
        if (rd_data !== e)
        begin
            err_count++;
            $display("wrong value reg %h expected %h seen %h", a, e, rd_data);
        end
    endtask
    task automatic check_pin(input string n, input logic [15:0] e);
        logic [15:0] s;
        @(negedge clk_sys);
        s = (n == "level") ? level_out : {15'h0, list_running};
        n_tests++;
        if (s !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // Bounded wait for the end of a run, 1 ms per step
    task automatic wait_done();
        int k;
        k = 0;
        while (list_running !== 1'b0 && k < 40000)
        begin
            @(posedge clk_sys);
            k++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        check_word(OFS_CTRL, 32'h0);
        check_word(OFS_REPEAT, RST_REPEAT);
        wr(OFS_CTRL, 32'h4);
        wr(OFS_LEVEL, 32'h0a11);
        wr(OFS_LEVEL, 32'h0b22);
        wr(OFS_DWELL, 32'h1);
        check_word(OFS_FILL, {2'h0, 10'd0, 10'd1, 10'd2});
        wr(OFS_QPTR, 32'h1);
        wr(OFS_WINSEL, {30'h0, WIN_LEVEL});
        check_word(OFS_WIN0, 32'h0b22);
        check_word(OFS_WIN0 + 8'h4, 32'h0);
        wr(OFS_QPTR, 32'd1002);
        check_word(OFS_QPTR, 32'h1);
        wr(OFS_ORDER, 32'h0);
        wr(OFS_ORDER, 32'h0);
        wr(OFS_ORDER, 32'h1);
        check_word(OFS_FILL, {2'h0, 10'd3, 10'd1, 10'd2});
        wr(OFS_WINSEL, {30'h0, WIN_SEQ});
        wr(OFS_QPTR, 32'h0);
        check_word(OFS_WIN0 + 8'h8, 32'h1);
        check_word(8'h80, 32'h0);
        // Default order reversed, single dwell for both steps
        wr(OFS_CTRL, 32'h2);
        wr(OFS_MODE, {30'h0, MODE_LIST});
        check_pin("running", 16'h1);
        wait_done();
        check_pin("level", 16'h0a11);
        // Two dwells against three levels must refuse the start
        wr(OFS_DWELL, 32'h1);
        wr(OFS_LEVEL, 32'h0c33);
        wr(OFS_MODE, {30'h0, MODE_LIST});
        check_pin("running", 16'h0);
        check_word(OFS_ERROR, {16'h0, ERR_CONFLICT});
        wr(OFS_ERROR, 32'h0);
        wr(OFS_DWELL, 32'h1);
        // User order 0,0,1 kept across a switch, appended level ignored
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h1);
        check_word(OFS_CTRL, 32'h1);
        check_word(OFS_WIN0 + 8'h8, 32'h1);
        wr(OFS_MODE, {30'h0, MODE_LIST});
        wait_done();
        check_pin("level", 16'h0b22);
        // Endless repeat with lead skip, rejection, fixed-mode stop
        wr(OFS_CTRL, 32'h0);
        wr(OFS_REPEAT, 32'h0);
        wr(OFS_SKIP, 32'h1);
        wr(OFS_QPTR, 32'h5);
        wr(8'h90, 32'h0d44);
        wr(OFS_MODE, {30'h0, MODE_LIST});
        // Mid second pass: step 0 skipped, so step 1 is showing
        repeat (31000) @(posedge clk_sys);
        check_pin("running", 16'h1);
        check_pin("level", 16'h0b22);
        check_word(OFS_QPTR, 32'h0);
        check_word(OFS_ERROR, {16'h0, ERR_CONFLICT});
        check_word(OFS_MODE, {30'h0, MODE_LIST});
        wr(OFS_MODE, {30'h0, MODE_FIXED});
        repeat (2) @(posedge clk_sys);
        check_pin("running", 16'h0);
        check_pin("level", 16'h0d44);
        // One 1 ms transient, then the earlier level returns
        wr(OFS_TRANS, 32'h1);
        check_word(OFS_MODE, {30'h0, MODE_TRANS});
        wr(8'h90, 32'h0e55);
        check_pin("level", 16'h0e55);
        repeat (10100) @(posedge clk_sys);
        check_pin("level", 16'h0d44);
        wrap_up();
    end
endmodule
bind lsq_list_sequencer lsq_list_sequencer_assertions #(.LEVEL_W(LEVEL_W))
    chk_i (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .level_out(level_out),
    .list_running(list_running));
`default_nettype wire
